/* sfrc_pkg.sv */
// Package with register layout, reset values and widths of the FIFO request control
package sfrc_pkg;
    // =====================================================
    // Register field positions
    localparam int TX_IRQ_EN_BIT = 7;     // Transmit request interrupt enable
    localparam int TX_FLUSH_BIT  = 6;     // Transmit flush, self clearing
    localparam int TX_TH_HI      = 5;     // Transmit threshold, upper bit
    localparam int TX_TH_LO      = 4;     // Transmit threshold, lower bit
    localparam int RX_IRQ_EN_BIT = 3;     // Receive request interrupt enable
    localparam int RX_FLUSH_BIT  = 2;     // Receive flush, self clearing
    localparam int RX_TH_HI      = 1;     // Receive threshold, upper bit
    localparam int RX_TH_LO      = 0;     // Receive threshold, lower bit

    // =====================================================
    // Widths and reset values
    localparam int          REG_W       = 8;          // Register width
    localparam int          TH_W        = 2;          // Threshold field width
    localparam int          CNT_W       = 3;          // Default FIFO count width
    localparam logic [7:0]  CTRL_RESET  = 8'h00;      // Whole register after reset
    localparam logic [1:0]  TH_ZERO     = 2'h0;       // Threshold value zero
endpackage

/* sfrc_fifo_request_control.sv */
// FIFO request, interrupt and flush control for the serial engine byte FIFOs
`timescale 1ns/1ps
// =====================================================
// Summary of operation
// - Transmit threshold zero: request only when empty
// - Receive interrupt enable is bit 3, resets 0
// - Enabled receive request raises the interrupt
// - Receive flush resets counters, clears after cycle
// - Receive request when count exceeds threshold
// - Transmit request when count at most threshold
// - Transmit flush resets counters, clears after cycle
// =====================================================
module sfrc_fifo_request_control #(
    parameter int CNT_W = sfrc_pkg::CNT_W                  // FIFO byte count width
) (
    input  wire logic                         clk_sys,     // System clock
    input  wire logic                         reset,       // Asynchronous reset
    input  wire logic                         regWrEn,     // Control register write strobe
    input  wire logic [sfrc_pkg::REG_W-1:0]   regWrData,   // Control register write data
    output logic      [sfrc_pkg::REG_W-1:0]   regRdData,   // Control register read data
    input  wire logic [CNT_W-1:0]             txFifoCount, // Bytes in transmit FIFO
    input  wire logic [CNT_W-1:0]             rxFifoCount, // Bytes in receive FIFO
    output logic                              txRequestFlag, // Transmit request level
    output logic                              rxRequestFlag, // Receive request level
    output logic                              smbIrq,      // Serial engine interrupt
    output logic                              txFlush,     // Transmit counter reset pulse
    output logic                              rxFlush      // Receive counter reset pulse
);

    // =====================================================
    // Control state
    logic                        txIrqEn_q;      // Transmit request interrupt enable
    logic                        rxIrqEn_q;      // Receive request interrupt enable
    logic [sfrc_pkg::TH_W-1:0]   txThreshold_q;  // Transmit threshold field
    logic [sfrc_pkg::TH_W-1:0]   rxThreshold_q;  // Receive threshold field
    logic                        txFlush_q;      // Transmit flush bit
    logic                        rxFlush_q;      // Receive flush bit
    logic [sfrc_pkg::REG_W-1:0]  rdData_q;       // Read data register
    logic                        irq_q;          // Interrupt register
    logic                        txReq;          // Transmit request, combinational
    logic                        rxReq;          // Receive request, combinational

    // Widen a threshold to the count width for comparison
    function automatic logic [CNT_W-1:0] widenTh(input logic [sfrc_pkg::TH_W-1:0] th);
        logic [CNT_W-1:0] w;
        w = '0;
        w[sfrc_pkg::TH_W-1:0] = th;
        return w;
    endfunction

    // =====================================================
    // Enables and thresholds, written by firmware
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            txIrqEn_q     <= sfrc_pkg::CTRL_RESET[sfrc_pkg::TX_IRQ_EN_BIT];
            rxIrqEn_q     <= sfrc_pkg::CTRL_RESET[sfrc_pkg::RX_IRQ_EN_BIT];
            txThreshold_q <= sfrc_pkg::CTRL_RESET[sfrc_pkg::TX_TH_HI:sfrc_pkg::TX_TH_LO];
            rxThreshold_q <= sfrc_pkg::CTRL_RESET[sfrc_pkg::RX_TH_HI:sfrc_pkg::RX_TH_LO];
        end
        else if (regWrEn)
        begin
            // Plain read-write fields
            txIrqEn_q     <= regWrData[sfrc_pkg::TX_IRQ_EN_BIT];
            rxIrqEn_q     <= regWrData[sfrc_pkg::RX_IRQ_EN_BIT];
            txThreshold_q <= regWrData[sfrc_pkg::TX_TH_HI:sfrc_pkg::TX_TH_LO];
            rxThreshold_q <= regWrData[sfrc_pkg::RX_TH_HI:sfrc_pkg::RX_TH_LO];
        end
    end

    // =====================================================
    // Flush bits: set by a write of one, dropped by hardware next cycle
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            txFlush_q <= 1'b0;
            rxFlush_q <= 1'b0;
        end
        else
        begin
            // High for exactly one cycle after the write
            txFlush_q <= regWrEn && regWrData[sfrc_pkg::TX_FLUSH_BIT] && !txFlush_q;
            rxFlush_q <= regWrEn && regWrData[sfrc_pkg::RX_FLUSH_BIT] && !rxFlush_q;
        end
    end

    // =====================================================
    // Request levels from FIFO counts
    always_comb
    begin
        // At or below threshold; threshold zero means empty only
        txReq = (txFifoCount <= widenTh(txThreshold_q));
        // Above threshold; threshold zero means not empty
        rxReq = (rxFifoCount > widenTh(rxThreshold_q));
    end

    // =====================================================
    // Interrupt, level while an enabled request stands
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= (rxIrqEn_q && rxReq) || (txIrqEn_q && txReq);
        end
    end

    // =====================================================
    // Read data, the register as it stands
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            rdData_q <= sfrc_pkg::CTRL_RESET;
        end
        else
        begin
            rdData_q <= {txIrqEn_q, txFlush_q, txThreshold_q,
                         rxIrqEn_q, rxFlush_q, rxThreshold_q};
        end
    end

    // Output drive
    assign regRdData     = rdData_q;
    assign txRequestFlag = txReq;
    assign rxRequestFlag = rxReq;
    assign smbIrq        = irq_q;
    assign txFlush       = txFlush_q;
    assign rxFlush       = rxFlush_q;

    // =====================================================
    // Checks
    // Firmware write of the receive flush bit while it is low
    sequence sFlushWrite;
        regWrEn && regWrData[sfrc_pkg::RX_FLUSH_BIT] && !rxFlush;
    endsequence

    // Firmware write of the transmit flush bit while it is low
    sequence sTxFlushWrite;
        regWrEn && regWrData[sfrc_pkg::TX_FLUSH_BIT] && !txFlush;
    endsequence

    // Any firmware write; it shows on the read port two edges later
    sequence sRegWrite;
        regWrEn;
    endsequence

    // Receive flush high for one cycle, then low again
    sequence sRxPulse;
        rxFlush ##1 !rxFlush;
    endsequence

    // Transmit flush high for one cycle, then low again
    sequence sTxPulse;
        txFlush ##1 !txFlush;
    endsequence

    // =====================================================
    // Request levels against the thresholds
    // Threshold zero: request exactly while the transmit FIFO is empty
    a_tx_zero_empty: assert property (@(posedge clk_sys) disable iff (reset)
        (txThreshold_q == sfrc_pkg::TH_ZERO) |-> (txRequestFlag == (txFifoCount == '0)))
        else $error("tx request wrong at threshold zero");
    // Receive request above the threshold
    a_rx_threshold: assert property (@(posedge clk_sys) disable iff (reset)
        rxRequestFlag == (rxFifoCount > widenTh(rxThreshold_q)))
        else $error("rx request wrong against threshold");
    // Threshold zero: request exactly while the receive FIFO holds data
    a_rx_zero_any: assert property (@(posedge clk_sys) disable iff (reset)
        (rxThreshold_q == sfrc_pkg::TH_ZERO) |-> (rxRequestFlag == (rxFifoCount != '0)))
        else $error("rx request wrong at threshold zero");
    // Transmit request at or below the threshold
    a_tx_threshold: assert property (@(posedge clk_sys) disable iff (reset)
        txRequestFlag == (txFifoCount <= widenTh(txThreshold_q)))
        else $error("tx request wrong against threshold");
    // Receive request drops in the same cycle as the count
    a_rx_fall_now: assert property (@(posedge clk_sys) disable iff (reset)
        (rxFifoCount <= widenTh(rxThreshold_q)) |-> !rxRequestFlag)
        else $error("rx request late to drop");

    // =====================================================
    // Register fields and readback
    // Receive interrupt enable reads zero right after reset
    a_rx_en_reset: assert property (@(posedge clk_sys)
        $fell(reset) |-> !regRdData[sfrc_pkg::RX_IRQ_EN_BIT])
        else $error("rx irq enable not zero after reset");
    // Receive interrupt enable reads back what was written
    a_rx_en_write: assert property (@(posedge clk_sys) disable iff (reset)
        sRegWrite |=> ##1
            (regRdData[sfrc_pkg::RX_IRQ_EN_BIT] == $past(regWrData[sfrc_pkg::RX_IRQ_EN_BIT], 2)))
        else $error("rx irq enable not read back");
    // Receive threshold reads back what was written
    a_rx_th_write: assert property (@(posedge clk_sys) disable iff (reset)
        sRegWrite |=> ##1 (regRdData[sfrc_pkg::RX_TH_HI:sfrc_pkg::RX_TH_LO] ==
            $past(regWrData[sfrc_pkg::RX_TH_HI:sfrc_pkg::RX_TH_LO], 2)))
        else $error("rx threshold not read back");
    // Transmit threshold reads back what was written
    a_tx_th_write: assert property (@(posedge clk_sys) disable iff (reset)
        sRegWrite |=> ##1 (regRdData[sfrc_pkg::TX_TH_HI:sfrc_pkg::TX_TH_LO] ==
            $past(regWrData[sfrc_pkg::TX_TH_HI:sfrc_pkg::TX_TH_LO], 2)))
        else $error("tx threshold not read back");

    // =====================================================
    // Interrupt gating
    // Enabled receive request raises the interrupt next cycle
    a_rx_irq_raise: assert property (@(posedge clk_sys) disable iff (reset)
        (rxIrqEn_q && rxRequestFlag) |=> smbIrq)
        else $error("rx request did not raise irq");
    // Both enables low: no interrupt at all
    a_rx_irq_quiet: assert property (@(posedge clk_sys) disable iff (reset)
        (!rxIrqEn_q && !txIrqEn_q) |=> !smbIrq)
        else $error("irq raised while disabled");
    // Receive enable low: the receive flag alone raises nothing
    a_rx_irq_off: assert property (@(posedge clk_sys) disable iff (reset)
        (!rxIrqEn_q && !(txIrqEn_q && txRequestFlag)) |=> !smbIrq)
        else $error("disabled rx request raised irq");

    // =====================================================
    // Flush pulses
    // Flush outputs low on the first edge after reset
    a_flush_reset_low: assert property (@(posedge clk_sys)
        $fell(reset) |-> (!rxFlush && !txFlush))
        else $error("flush high after reset");
    // Receive flush write gives a single pulse
    a_rx_flush_once: assert property (@(posedge clk_sys) disable iff (reset)
        sFlushWrite |=> sRxPulse)
        else $error("rx flush not a single cycle");
    // Receive flush bit reads as one for its cycle
    a_rx_flush_read: assert property (@(posedge clk_sys) disable iff (reset)
        rxFlush |=> regRdData[sfrc_pkg::RX_FLUSH_BIT])
        else $error("rx flush bit not read back");
    // Transmit flush write gives a single pulse
    a_tx_flush_once: assert property (@(posedge clk_sys) disable iff (reset)
        sTxFlushWrite |=> sTxPulse)
        else $error("tx flush not a single cycle");
    // Transmit flush bit reads as one for its cycle
    a_tx_flush_read: assert property (@(posedge clk_sys) disable iff (reset)
        txFlush |=> regRdData[sfrc_pkg::TX_FLUSH_BIT])
        else $error("tx flush bit not read back");
endmodule

/* sfrc_fifo_model.sv */
// Behavioural model of the serial engine's FIFO byte counters
`timescale 1ns/1ps
module sfrc_fifo_model (
    input  wire logic       clk_sys,     // System clock
    input  wire logic       reset,       // Asynchronous reset
    input  wire logic       txLoadEn,    // Load a new transmit count
    input  wire logic       rxLoadEn,    // Load a new receive count
    input  wire logic [2:0] loadCount,   // Count to load
    input  wire logic       txFlush,     // Transmit flush pulse
    input  wire logic       rxFlush,     // Receive flush pulse
    output logic      [2:0] txFifoCount, // Bytes held for transmit
    output logic      [2:0] rxFifoCount  // Bytes held from receive
);
    // =====================================================
    // Counters: a flush wins over a load
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            {txFifoCount, rxFifoCount} <= 6'h00;
        else
        begin
            txFifoCount <= txFlush ? 3'h0 : (txLoadEn ? loadCount : txFifoCount);
            rxFifoCount <= rxFlush ? 3'h0 : (rxLoadEn ? loadCount : rxFifoCount);
        end
    end
endmodule

/* tb.sv */
// Self-checking bench for the FIFO request control
`timescale 1ns/1ps
module tb;
    // =====================================================
    // Bench signals
    logic       clk_sys = 1'b0;                  // System clock
    logic       reset = 1'b1;                    // Reset, held at start
    logic       regWrEn = 1'b0;                  // Write strobe
    logic [7:0] regWrData = 8'h00;               // Write data
    logic [7:0] regRdData;                       // Read data
    logic       txLoadEn = 1'b0, rxLoadEn = 1'b0; // Count loads
    logic [2:0] loadCount = 3'h0, txFifoCount, rxFifoCount;
    logic       txRequestFlag, rxRequestFlag, smbIrq, txFlush, rxFlush;
    int         n_errors = 0, n_checks = 0, cycles = 0;
    initial forever #10 clk_sys = ~clk_sys;
    sfrc_fifo_request_control u_dut (.clk_sys(clk_sys), .reset(reset), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdData(regRdData), .txFifoCount(txFifoCount),
        .rxFifoCount(rxFifoCount), .txRequestFlag(txRequestFlag),
        .rxRequestFlag(rxRequestFlag), .smbIrq(smbIrq), .txFlush(txFlush), .rxFlush(rxFlush));
    sfrc_fifo_model u_model (.clk_sys(clk_sys), .reset(reset), .txLoadEn(txLoadEn),
        .rxLoadEn(rxLoadEn), .loadCount(loadCount), .txFlush(txFlush), .rxFlush(rxFlush),
        .txFifoCount(txFifoCount), .rxFifoCount(rxFifoCount));
    // =====================================================
    // Tasks: compare, register write, count load, verdict
    task automatic chk(input logic [7:0] act, input logic [7:0] exp, input string msg);
        n_checks++;
        if (act !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    task automatic wr(input logic [7:0] d);
        @(posedge clk_sys);
        regWrEn <= 1'b1;
        regWrData <= d;
        @(posedge clk_sys);
        regWrEn <= 1'b0;
        #1;
    endtask
    task automatic load(input logic tx, input logic [2:0] n);
        @(posedge clk_sys);
        txLoadEn <= tx;
        rxLoadEn <= ~tx;
        loadCount <= n;
        @(posedge clk_sys);
        {txLoadEn, rxLoadEn} <= 2'b00;
        #1;
    endtask
    task automatic test_done;
        $display("checks %0d, mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Hang guard
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            n_errors++;
            $display("unexpected at %0t: cycle limit reached", $time);
            test_done;
        end
    end
    // =====================================================
    // Main sequence
    initial
    begin
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        #1 chk(regRdData, 8'h00, "register reset value");
        for (int th = 0; th < 4; th++)
        begin
            wr({2'b00, 2'(th), 2'b00, 2'(th)});
            for (int n = 0; n < 8; n++)
            begin
                load(1'b1, 3'(n));
                load(1'b0, 3'(n));
                chk(8'(txRequestFlag), 8'(n <= th), "tx request level");
                chk(8'(rxRequestFlag), 8'(n > th), "rx request level");
                chk(8'(smbIrq), 8'h00, "irq while disabled");
            end
        end
        $display("threshold test done");
        wr(8'h08);
        @(posedge clk_sys);
        #1 chk(regRdData, 8'h08, "enable readback");
        chk(8'(smbIrq), 8'h01, "irq raised");
        wr(8'h0C);
        chk(8'(rxFlush), 8'h01, "rx flush pulse");
        @(posedge clk_sys);
        #1 chk({rxFlush, rxRequestFlag}, 8'h00, "rx flush clears");
        @(posedge clk_sys);
        #1 chk(8'(smbIrq), 8'h00, "irq drops");
        load(1'b1, 3'h5);
        wr(8'h40);
        chk({txFlush, txRequestFlag}, 8'h02, "tx flush pulse");
        @(posedge clk_sys);
        #1 chk({txFlush, txRequestFlag}, 8'h01, "tx flush clears");
        wr(8'h80);
        chk(8'(smbIrq), 8'h00, "tx irq one cycle late");
        @(posedge clk_sys);
        #1 chk(8'(smbIrq), 8'h01, "tx request raises irq");
        load(1'b1, 3'h1);
        chk(8'(txRequestFlag), 8'h00, "tx request drops above zero");
        @(posedge clk_sys);
        #1 chk(8'(smbIrq), 8'h00, "tx irq drops");
        $display("flush and irq test done");
        @(posedge clk_sys);
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        #1 chk(regRdData, 8'h00, "register after mid reset");
        chk(8'(smbIrq), 8'h00, "irq after mid reset");
        chk(8'(txRequestFlag), 8'h01, "tx request after mid reset");
        $display("mid reset test done");
        test_done;
    end
endmodule
